// File: shared/xic_map.svh
// register address, bit positions and reset values of the extra interrupt control block
`ifndef XIC_MAP_SVH
`define XIC_MAP_SVH

// ****************************************
// register and bit addresses, reset value
// ****************************************
`define XIC_CTRL_ADDR      8'hc0
`define XIC_BIT_BASE       8'hc0
`define XIC_CTRL_RESET     8'h00

// ****************************************
// field positions
// ****************************************
`define XIC_IRQ2_EDGE_POS  3'h0
`define XIC_IRQ2_FLAG_POS  3'h1
`define XIC_IRQ2_EN_POS    3'h2
`define XIC_IRQ2_PRIO_POS  3'h3
`define XIC_IRQ3_EDGE_POS  3'h4
`define XIC_IRQ3_FLAG_POS  3'h5
`define XIC_IRQ3_EN_POS    3'h6
`define XIC_IRQ3_PRIO_POS  3'h7

// ****************************************
// vectors and polling order
// ****************************************
`define XIC_IRQ2_VECTOR    8'h33
`define XIC_IRQ3_VECTOR    8'h3b
`define XIC_IRQ2_POLL      3'h6
`define XIC_IRQ3_POLL      3'h7

// machine cycle length in core clocks
`define XIC_SAMPLE_DIV     8'h0c

`endif

// File: shared/xic_pkg.sv
// types shared by the extra interrupt control block
package xic_pkg;

    // one nibble per input, msb first
    typedef struct packed {
        logic high_priority;
        logic enable;
        logic pending_flag;
        logic edge_select;
    } xic_chan_t;

    typedef struct packed {
        xic_chan_t irq3;
        xic_chan_t irq2;
    } xic_ctrl_t;

    // request toward the interrupt system
    typedef struct packed {
        logic       request;
        logic       high_priority;
        logic [7:0] vector;
        logic [2:0] poll_order;
    } xic_req_t;

    typedef enum logic [1:0] {
        XIC_SEQ_IDLE = 2'b01,
        XIC_SEQ_TICK = 2'b10
    } xic_seq_t;

endpackage : xic_pkg

// File: verilog/xic_chan.sv
// one extra external interrupt channel: pin sync, sampling, flag
`timescale 1ns/1ps
`include "xic_map.svh"

module xic_chan (
    input  wire logic clk,
    input  wire logic reset,
    input  wire logic pin_n,
    input  wire logic alt_enable,
    input  wire logic sample_tick,
    input  wire logic edge_select,
    input  wire logic flag_write,
    input  wire logic flag_wdata,
    input  wire logic serviced,
    output logic      pending_flag
);
    import xic_pkg::*;

    logic sync_a;
    logic sync_b;
    logic last_sample;
    logic cur_sample;
    logic next_flag;
    wire  fall_seen;
    wire  level_low;

    // ****************************************
    // pin synchroniser
    // ****************************************
    // first stage feeds only the second one
    always_ff @(posedge clk) begin
        sync_a <= pin_n;
        sync_b <= sync_a;
    end

    // ****************************************
    // machine cycle sampling
    // ****************************************
    // pin as gpio reads idle high, so it never raises a request
    always_ff @(posedge clk) begin
        if (reset) begin
            cur_sample  <= 1'b1;
            last_sample <= 1'b1;
        end else if (sample_tick) begin
            cur_sample  <= alt_enable ? sync_b : 1'b1;
            last_sample <= cur_sample;
        end
    end

    // falling edge from one sample to the next
    assign fall_seen = sample_tick & last_sample & ~cur_sample;
    assign level_low = ~cur_sample;

    // set beats service and software clear in the same cycle
    always_comb begin
        next_flag = pending_flag;
        if (edge_select) begin
            if (flag_write) next_flag = flag_wdata;
            else if (serviced) next_flag = 1'b0;
            if (fall_seen) next_flag = 1'b1;
        end else begin
            next_flag = level_low;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) pending_flag <= 1'b0;
        else pending_flag <= next_flag;
    end

endmodule : xic_chan

// File: verilog/xic_ctrl.sv
// extra external interrupt control register and request outputs
// Contract
// - the control register sits at special-function address c0h, bits msb first irq3 prio, en, flag, type, then irq2.
// - both extra inputs behave like the standard external interrupts with their own controls.
// - irq3 priority bit set gives irq3 the high level, clear gives the low level.
// - irq3 requests reach the processor only while irq3 is enabled.
// - in edge mode a falling edge sets the irq3 flag and service clears it.
// - irq3 type bit set means falling-edge trigger, clear means low-level trigger.
// - irq2 priority bit set gives irq2 the high level, clear gives the low level.
// - irq2 requests reach the processor only while irq2 is enabled.
// - in edge mode a falling edge sets the irq2 flag and service clears it.
// - irq2 type bit set means falling-edge trigger, clear means low-level trigger.
// - the inputs come from aux port bits 2 and 3 only when their alternate function is selected.
// - irq2 vectors to 33h polled sixth, irq3 to 3bh polled seventh and last.
`timescale 1ns/1ps
`include "xic_map.svh"

module xic_ctrl #(
    parameter logic [7:0] SAMPLE_DIV = `XIC_SAMPLE_DIV
) (
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic [7:0] sfr_addr,
    input  wire logic       sfr_write,
    input  wire logic [7:0] sfr_wdata,
    input  wire logic [7:0] bit_addr,
    input  wire logic       bit_write,
    input  wire logic       bit_wdata,
    output logic [7:0]      sfr_rdata,
    output logic            sfr_hit,
    output logic            bit_rdata,
    output logic            bit_hit,
    input  wire logic [3:0] aux_nibble_port,
    input  wire logic [1:0] alt_select,
    input  wire logic       irq2_ack,
    input  wire logic       irq3_ack,
    output xic_pkg::xic_req_t irq2_req,
    output xic_pkg::xic_req_t irq3_req
);
    import xic_pkg::*;

    xic_ctrl_t  ctrl;
    xic_seq_t   seq;
    logic [7:0] div_cnt;
    logic       flag2;
    logic       flag3;
    wire        byte_sel;
    wire        bit_sel;
    wire [2:0]  bit_pos;
    wire [7:0]  ctrl_bits;
    wire [7:0]  bit_mask;
    wire [7:0]  bit_base;
    wire [7:0]  write_value;
    wire        ctrl_write;
    wire        sample_tick;
    wire        flag2_write;
    wire        flag3_write;

    // ****************************************
    // address decode
    // ****************************************
    assign byte_sel = (sfr_addr == `XIC_CTRL_ADDR);
    // bit space c0h..c7h, compared on the upper five bits only
    assign bit_base = `XIC_BIT_BASE;
    assign bit_sel  = (bit_addr[7:3] == bit_base[7:3]);
    assign bit_pos  = bit_addr[2:0];
    assign bit_mask = 8'h01 << bit_pos;
    assign ctrl_bits = {ctrl.irq3.high_priority, ctrl.irq3.enable, flag3, ctrl.irq3.edge_select,
                        ctrl.irq2.high_priority, ctrl.irq2.enable, flag2, ctrl.irq2.edge_select};
    assign ctrl_write = (sfr_write & byte_sel) | (bit_write & bit_sel);
    // single-bit write leaves other bits untouched
    assign write_value = (sfr_write & byte_sel) ? sfr_wdata
                       : (bit_wdata ? (ctrl_bits | bit_mask) : (ctrl_bits & ~bit_mask));
    assign flag2_write = ctrl_write & ((sfr_write & byte_sel) | (bit_pos == `XIC_IRQ2_FLAG_POS));
    assign flag3_write = ctrl_write & ((sfr_write & byte_sel) | (bit_pos == `XIC_IRQ3_FLAG_POS));

    // ****************************************
    // read paths
    // ****************************************
    assign sfr_hit   = byte_sel;
    assign bit_hit   = bit_sel;
    assign sfr_rdata = byte_sel ? ctrl_bits : 8'h00;
    assign bit_rdata = bit_sel & ctrl_bits[bit_pos];

    // ****************************************
    // control bits (flags live in the channels)
    // ****************************************
    always_ff @(posedge clk) begin
        if (reset) begin
            ctrl <= xic_ctrl_t'(`XIC_CTRL_RESET);
        end else if (ctrl_write) begin
            ctrl <= xic_ctrl_t'(write_value);
        end
    end

    // ****************************************
    // machine cycle sequencer
    // ****************************************
    // one tick per machine cycle keeps edges as slow as the core sees them
    always_ff @(posedge clk) begin
        if (reset) begin
            div_cnt <= 8'h00;
            seq     <= XIC_SEQ_IDLE;
        end else begin
            case (seq)
                XIC_SEQ_IDLE: begin
                    div_cnt <= div_cnt + 8'h01;
                    if (div_cnt == SAMPLE_DIV - 8'h02) seq <= XIC_SEQ_TICK;
                end
                XIC_SEQ_TICK: begin
                    div_cnt <= 8'h00;
                    seq     <= XIC_SEQ_IDLE;
                end
                default: begin
                    div_cnt <= 8'h00;
                    seq     <= XIC_SEQ_IDLE;
                end
            endcase
        end
    end
    assign sample_tick = (seq == XIC_SEQ_TICK);

    // ****************************************
    // channels
    // ****************************************
    // both share one channel design, as the standard pair does
    xic_chan u_irq2 (
        .clk          (clk),
        .reset        (reset),
        .pin_n        (aux_nibble_port[2]),
        .alt_enable   (alt_select[0]),
        .sample_tick  (sample_tick),
        .edge_select  (ctrl.irq2.edge_select),
        .flag_write   (flag2_write),
        .flag_wdata   (write_value[`XIC_IRQ2_FLAG_POS]),
        .serviced     (irq2_ack),
        .pending_flag (flag2)
    );

    xic_chan u_irq3 (
        .clk          (clk),
        .reset        (reset),
        .pin_n        (aux_nibble_port[3]),
        .alt_enable   (alt_select[1]),
        .sample_tick  (sample_tick),
        .edge_select  (ctrl.irq3.edge_select),
        .flag_write   (flag3_write),
        .flag_wdata   (write_value[`XIC_IRQ3_FLAG_POS]),
        .serviced     (irq3_ack),
        .pending_flag (flag3)
    );

    // ****************************************
    // requests toward the interrupt system
    // ****************************************
    assign irq2_req.request       = flag2 & ctrl.irq2.enable;
    assign irq2_req.high_priority = ctrl.irq2.high_priority;
    assign irq2_req.vector        = `XIC_IRQ2_VECTOR;
    assign irq2_req.poll_order    = `XIC_IRQ2_POLL;
    assign irq3_req.request       = flag3 & ctrl.irq3.enable;
    assign irq3_req.high_priority = ctrl.irq3.high_priority;
    assign irq3_req.vector        = `XIC_IRQ3_VECTOR;
    assign irq3_req.poll_order    = `XIC_IRQ3_POLL;

endmodule : xic_ctrl

// File: tb/xic_ctrl_properties.sv
// concurrent checks on the control block's ports
`timescale 1ns/1ps
module xic_ctrl_properties (
    input wire logic              clk,
    input wire logic              reset,
    input wire logic [7:0]        sfr_addr,
    input wire logic              sfr_write,
    input wire logic [7:0]        sfr_wdata,
    input wire logic [7:0]        sfr_rdata,
    input wire logic              sfr_hit,
    input wire xic_pkg::xic_req_t irq2_req,
    input wire xic_pkg::xic_req_t irq3_req
);
    import xic_pkg::*;
    // one domain, so clock and reset are given once
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);
    a_map_hit: assert property (sfr_hit == (sfr_addr == 8'hc0) && (sfr_hit || sfr_rdata == 8'h00))
        else $error("register decode wrong");
    a_irq2_gate: assert property (sfr_hit |-> irq2_req.request == (sfr_rdata[1] && sfr_rdata[2]))
        else $error("irq2 request not flag and enable");
    a_irq3_gate: assert property (sfr_hit |-> irq3_req.request == (sfr_rdata[5] && sfr_rdata[6]))
        else $error("irq3 request not flag and enable");
    a_irq2_prio: assert property (sfr_hit |-> irq2_req.high_priority == sfr_rdata[3])
        else $error("irq2 level wrong");
    a_irq3_prio: assert property (sfr_hit |-> irq3_req.high_priority == sfr_rdata[7])
        else $error("irq3 level wrong");
    a_byte_store: assert property (sfr_write && sfr_addr == 8'hc0 |=> irq3_req.high_priority == $past(sfr_wdata[7]))
        else $error("byte store lost");
    a_fixed_vec: assert property (irq2_req.vector == 8'h33 && irq2_req.poll_order == 3'h6
        && irq3_req.vector == 8'h3b && irq3_req.poll_order == 3'h7) else $error("vector or poll order wrong");
    a_reset_quiet: assert property (disable iff (1'b0) reset |=> !irq2_req.request && !irq3_req.request)
        else $error("request after reset");
endmodule : xic_ctrl_properties
bind xic_ctrl xic_ctrl_properties props_u (.clk(clk), .reset(reset), .sfr_addr(sfr_addr), .sfr_write(sfr_write),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit), .irq2_req(irq2_req), .irq3_req(irq3_req));

// File: tb/xic_src_model.sv
// far-side model: interrupt sources on the aux port pins
`timescale 1ns/1ps
module xic_src_model (
    input wire logic       clk,
    input wire logic       slow,
    input wire logic [1:0] low,
    output logic [3:0]     pins
);
    logic [1:0] lag = 2'h0;
    logic [1:0] io = 2'h0;
    // slow sources follow a clock late; spare bits toggle as plain i/o
    always @(posedge clk) begin
        lag <= low;
        io <= io + 2'h1;
    end
    assign pins = {~(slow ? lag : low), io};
endmodule : xic_src_model

// File: tb/test_xic_ctrl.sv
// self-checking bench for the extra interrupt control block
`timescale 1ns/1ps
module test_xic_ctrl;
    import xic_pkg::*;
    localparam logic [7:0] DIV = 8'h04;
    logic        clk = 1'b0, reset = 1'b1, slow = 1'b0, probe = 1'b0;
    logic        sfr_write = 1'b0, bit_write = 1'b0, bit_wdata = 1'b0, sfr_hit, bit_hit, bit_rdata;
    logic [7:0]  sfr_addr = 8'h00, sfr_wdata = 8'h00, bit_addr = 8'h00, sfr_rdata, m, f;
    logic [1:0]  alt = 2'h3, ack = 2'h0, low = 2'h0;
    logic [3:0]  pins;
    xic_req_t    irq2_req, irq3_req;
    logic [12:0] q[$];
    int          n_errors = 0, checks_done = 0, seed = 69250;
    // 200 MHz core clock
    always #2.5 clk = ~clk;
    xic_ctrl #(.SAMPLE_DIV(DIV)) dut_u (.clk(clk), .reset(reset), .sfr_addr(sfr_addr), .sfr_write(sfr_write),
        .sfr_wdata(sfr_wdata), .bit_addr(bit_addr), .bit_write(bit_write), .bit_wdata(bit_wdata),
        .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit), .bit_rdata(bit_rdata), .bit_hit(bit_hit), .aux_nibble_port(pins),
        .alt_select(alt), .irq2_ack(ack[0]), .irq3_ack(ack[1]), .irq2_req(irq2_req), .irq3_req(irq3_req));
    xic_src_model src_u (.clk(clk), .slow(slow), .low(low), .pins(pins));
    task automatic conclude();
        $display("errors %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : conclude
    task automatic cmp(input logic [12:0] e, input logic [12:0] g);
        checks_done++;
        if (g !== e) begin
            n_errors++;
            $display("Error at %0t: got %h want %h", $time, g, e);
        end
    endtask : cmp
    // one cycle of strobes {probe, byte, bit, acks}; a probe notes what image v should show
    task automatic op(input logic [4:0] s, input logic [7:0] a, input logic [7:0] v);
        @(negedge clk);
        {probe, sfr_write, bit_write, ack} = s;
        {sfr_addr, bit_addr, sfr_wdata, bit_wdata} = {a, a, v, v[0]};
        if (s[4])
            q.push_back({a[7:3] == 5'h18, v[a[2:0]] & (a[7:3] == 5'h18), a == 8'hc0, v[5] & v[6], v[1] & v[2],
                         (a == 8'hc0) ? v : 8'h00});
        @(negedge clk);
        {probe, sfr_write, bit_write, ack} = 5'h00;
    endtask : op
    // bounded wait for a flag; running out ends the run
    task automatic wt(input int b, input logic v);
        int n = 0;
        @(negedge clk);
        sfr_addr = 8'hc0;
        while (sfr_rdata[b] !== v && n < 200) begin
            @(negedge clk);
            n++;
        end
        if (sfr_rdata[b] !== v) begin
            cmp(13'h0001, 13'h0000);
            conclude();
        end
    endtask : wt
    // monitor: oldest note against hit, requests and read data
    always @(posedge clk) begin
        if (probe)
            cmp(q.pop_front(), {bit_hit, bit_rdata, sfr_hit, irq3_req.request, irq2_req.request, sfr_rdata});
    end
    initial begin
        repeat (20) @(posedge clk);
        @(negedge clk);
        reset = 1'b0;
        op(5'h10, 8'hc0, 8'h00);
        // random priority and enable images, plus an unmapped read
        repeat (4) begin
            m = 8'($random(seed)) & 8'hcc;
            op(5'h08, 8'hc0, m);
            op(5'h10, 8'hc0, m);
            op(5'h10, 8'hc1, m);
        end
        // single-bit stores, one at an unmapped bit address
        op(5'h08, 8'hc0, 8'h00);
        op(5'h04, 8'hc2, 8'h01);
        op(5'h04, 8'hc8, 8'h01);
        op(5'h04, 8'hc7, 8'h01);
        op(5'h10, 8'hc0, 8'h84);
        // bit reads: one mapped bit, one outside the bit space
        op(5'h10, 8'hc7, 8'h84);
        op(5'h10, 8'hc8, 8'h84);
        for (int k = 0; k < 2; k++) begin
            f = 8'h02 << (4 * k);
            slow = k[0];
            // edge mode: flag per fall, cleared by service, no refire while held
            op(5'h08, 8'hc0, 8'h55);
            low = 2'h1 << k;
            wt(1 + 4 * k, 1'b1);
            op(5'h10, 8'hc0, 8'h55 | f);
            op(5'h01 << k, 8'hc0, 8'h00);
            repeat (3 * DIV) @(negedge clk);
            op(5'h10, 8'hc0, 8'h55);
            // level mode: flag mirrors the pin, service ignored, enable gates
            op(5'h08, 8'hc0, 8'h44);
            wt(1 + 4 * k, 1'b1);
            op(5'h01 << k, 8'hc0, 8'h00);
            op(5'h10, 8'hc0, 8'h44 | f);
            op(5'h08, 8'hc0, 8'h00);
            op(5'h10, 8'hc0, f);
            low = 2'h0;
            wt(1 + 4 * k, 1'b0);
            // pin left as plain i/o never raises the flag
            alt = ~(2'h1 << k);
            low = 2'h1 << k;
            repeat (4 * DIV) @(negedge clk);
            op(5'h10, 8'hc0, 8'h00);
            low = 2'h0;
            repeat (4 * DIV) @(negedge clk);
            alt = 2'h3;
        end
        conclude();
    end
endmodule : test_xic_ctrl
